// >>> spsc_pkg.sv
// Constants and types shared by the suspend pin state control block.
// Assumes the pin setup and report decoders outside run on the same core clock.
package spsc_pkg;

	localparam int NPINS = 10;
	localparam int CFGW = 3;

	// Suspend behaviour word layout
	localparam int SUSP_USE_BIT = 15;
	localparam logic [15:0] SUSP_MODE_MASK = 16'hBCCF;
	localparam logic [15:0] SUSP_STATE_MASK = 16'h3CCF;
	localparam logic [15:0] SUSP_MODE_RESET = 16'h0000;
	localparam logic [15:0] SUSP_STATE_RESET = 16'h0000;

	// Report identifiers and lengths
	localparam logic [7:0] RPT_ID_LANG = 8'h67;
	localparam logic [7:0] RPT_ID_LOCK = 8'h68;
	localparam logic [2:0] RPT_LEN_LANG = 3'h3;
	localparam logic [2:0] RPT_LEN_LOCK = 3'h2;
	localparam logic [2:0] RPT_LEN_MAX = 3'h4;
	localparam int LOCK_REQ_BIT = 0;
	localparam logic [15:0] LANG_RESET = 16'h0409;

	// Pin configuration codes
	localparam logic [2:0] CFG_IN = 3'h0;
	localparam logic [2:0] CFG_OD = 3'h1;
	localparam logic [2:0] CFG_PP = 3'h2;
	localparam logic [2:0] CFG_ALT = 3'h3;
	localparam logic [2:0] CFG_ALT_PP = 3'h4;
	localparam logic [29:0] PIN_CFG_RESET = {3'h2, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0};

	typedef enum logic {SPSC_RUN, SPSC_SUSP} spsc_pwr_t;

	// Pin index to bit of the suspend words
	function automatic int susp_bit(input int pin);
		if (pin < 4) begin
			return pin;
		end else if (pin < 6) begin
			return pin + 2;
		end else begin
			return pin + 4;
		end
	endfunction : susp_bit

endpackage : spsc_pkg

// >>> spsc_pin_ctl.sv
// Per-pin output selection for normal running and for suspend.
// Assumes all inputs are on the core clock; the caller registers the results.
`timescale 1ns/10ps
module spsc_pin_ctl (
	// Configuration
	input wire logic [29:0] cfg,
	input wire logic flow_en,
	input wire logic rs485_io1,
	input wire logic [15:0] susp_mode,
	input wire logic [15:0] susp_state,
	// Sources
	input wire logic [9:0] gpio_val,
	input wire logic [9:0] func_val,
	input wire logic clk_lvl,
	// Suspend view
	input wire logic susp,
	input wire logic [9:0] held_out,
	input wire logic [9:0] held_oe_n,
	// Results
	output logic [9:0] norm_out,
	output logic [9:0] norm_oe_n,
	output logic [9:0] pin_out,
	output logic [9:0] pin_oe_n
);
	logic use_ovr;

	assign use_ovr = susp_mode[spsc_pkg::SUSP_USE_BIT];

	for (genvar i = 0; i < spsc_pkg::NPINS; i++) begin : g_pin
		localparam int SB = spsc_pkg::susp_bit(i);
		logic [2:0] code;
		logic alt;
		logic is_od;
		logic is_in;
		logic is_de;
		logic val;

		assign code = cfg[i*spsc_pkg::CFGW +: spsc_pkg::CFGW];
		assign alt = (code == spsc_pkg::CFG_ALT) || (code == spsc_pkg::CFG_ALT_PP);
		// Only the RTS and DTR slots have an open-drain alternate code
		assign is_od = (code == spsc_pkg::CFG_OD) || ((code == spsc_pkg::CFG_ALT) && (i == 1 || i == 8));
		assign is_in = !(alt || code == spsc_pkg::CFG_OD || code == spsc_pkg::CFG_PP) || (alt && i == 2);
		assign is_de = alt && (i == 3 || (i == 1 && rs485_io1));

		always_comb begin
			val = gpio_val[i];
			if (alt) begin
				if (i == 0) begin
					val = clk_lvl;
				end else if (i == 1 && !rs485_io1 && !flow_en) begin
					val = 1'b1;
				end else begin
					val = func_val[i];
				end
			end
		end

		always_comb begin
			norm_out[i] = 1'b0;
			norm_oe_n[i] = 1'b1;
			if (!is_in) begin
				if (is_od) begin
					norm_oe_n[i] = val;
				end else begin
					norm_out[i] = val;
					norm_oe_n[i] = 1'b0;
				end
			end
		end

		always_comb begin
			pin_out[i] = norm_out[i];
			pin_oe_n[i] = norm_oe_n[i];
			if (susp && !use_ovr) begin
				pin_out[i] = held_out[i];
				pin_oe_n[i] = held_oe_n[i];
			end else if (susp) begin
				if ((alt && i == 0) || is_de) begin
					pin_out[i] = 1'b0;
					pin_oe_n[i] = 1'b0;
				end else if (susp_mode[SB]) begin
					pin_out[i] = susp_state[SB];
					pin_oe_n[i] = 1'b0;
				end else begin
					pin_out[i] = 1'b0;
					pin_oe_n[i] = 1'b1;
				end
			end
		end
	end

endmodule : spsc_pin_ctl

// >>> spsc_top.sv
// Suspend pin state control: pin drive in run and suspend, pin defaults,
// language code and configuration lock reports.
// Assumes report, suspend and UART inputs come from logic on CLK; pins are asynchronous.
`timescale 1ns/10ps
// Overview of operation
// - Word bit 15 enables override; pin bits mapped
// - Override off: pins keep pre-suspend outputs
// - Override on: per-pin suspend level and mode
// - Override on: clock output pin driven low
// - Override on: RS-485 driver enables held deasserted
// - Receive pin is always UART serial input
// - Pin 3 resets to RS-485 enable code
// - Pins 1,2 do no flow control until enabled
// - Language code resets 0x0409, host read/write
// - Language report: id 0x67, low, high byte
// - Lock report: id 0x68, byte1 bit0 requests
// - Lock takes effect only after a reset
module spsc_top #(
	parameter int CLKOUT_DIV = 2
) (
	// Clock and resets
	input wire logic CLK,
	input wire logic RST,
	input wire logic POR_RST,
	// Pins
	input wire logic [9:0] GPIO_IN,
	output logic [9:0] GPIO_OUT,
	output logic [9:0] GPIO_OE_N,
	input wire logic RX_PIN,
	// UART side
	output logic RX_DATA,
	output logic [9:0] GPIO_IN_Q,
	input wire logic [9:0] GPIO_WR_VAL,
	input wire logic [9:0] UART_FUNC,
	input wire logic FLOW_EN,
	input wire logic RS485_IO1,
	output logic CTS_OK,
	// USB state
	input wire logic USB_SUSPEND,
	// Pin setup writes
	input wire logic PIN_CFG_WR,
	input wire logic [3:0] PIN_CFG_SEL,
	input wire logic [2:0] PIN_CFG_DATA,
	output logic [29:0] PIN_CFG_Q,
	input wire logic SUSP_WR,
	input wire logic [15:0] SUSP_MODE_DATA,
	input wire logic [15:0] SUSP_STATE_DATA,
	output logic [15:0] SUSP_MODE_Q,
	output logic [15:0] SUSP_STATE_Q,
	// Set report byte stream
	input wire logic SET_VALID,
	input wire logic SET_FIRST,
	input wire logic SET_LAST,
	input wire logic [7:0] SET_BYTE,
	output logic SET_DONE,
	output logic SET_ERR,
	// Get report
	input wire logic GET_REQ,
	input wire logic [7:0] GET_ID,
	output logic GET_ACK,
	output logic GET_ERR,
	output logic [1:0] GET_LEN,
	output logic [7:0] GET_B0,
	output logic [7:0] GET_B1,
	output logic [7:0] GET_B2,
	// Lock
	input wire logic LOCK_STORED,
	output logic LOCK_PENDING,
	output logic LOCKED
);
	localparam int DW = $clog2(CLKOUT_DIV + 1);

	if (CLKOUT_DIV < 1) begin : g_bad_div
		$error("CLKOUT_DIV must be at least 1");
	end

	logic rst_any;
	logic [9:0] gpio_s1_r, gpio_s2_r, gpio_in_q_r;
	logic rx_s1_r, rx_s2_r, rx_data_r, cts_ok_r;
	logic [29:0] pin_cfg_r;
	logic [15:0] susp_mode_r, susp_state_r, lang_r;
	spsc_pkg::spsc_pwr_t pwr_r;
	logic [9:0] held_out_r, held_oe_n_r, gpio_out_r, gpio_oe_n_r;
	logic [9:0] norm_out, norm_oe_n, pin_out, pin_oe_n;
	logic [DW-1:0] div_r;
	logic clk_lvl_r;
	logic [2:0] set_cnt_r;
	logic [7:0] set_b0_r, set_b1_r, set_b2_r;
	logic set_end_r, set_done_r, set_err_r;
	logic ok_lang, ok_lock;
	logic lock_req_r, locked_r;
	logic get_ack_r, get_err_r;
	logic [1:0] get_len_r;
	logic [7:0] get_b0_r, get_b1_r, get_b2_r;

	assign rst_any = RST || POR_RST;

	// Pin and receive synchronisers
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			gpio_s1_r <= 10'h3FF;
			gpio_s2_r <= 10'h3FF;
			gpio_in_q_r <= 10'h3FF;
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_data_r <= 1'b1;
			cts_ok_r <= 1'b1;
		end else begin
			gpio_s1_r <= GPIO_IN;
			gpio_s2_r <= gpio_s1_r;
			gpio_in_q_r <= gpio_s2_r;
			rx_s1_r <= RX_PIN;
			rx_s2_r <= rx_s1_r;
			rx_data_r <= rx_s2_r;
			cts_ok_r <= !FLOW_EN || !gpio_s2_r[2];
		end
	end

	// Pin setup; the lock freezes it
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			pin_cfg_r <= spsc_pkg::PIN_CFG_RESET;
			susp_mode_r <= spsc_pkg::SUSP_MODE_RESET;
			susp_state_r <= spsc_pkg::SUSP_STATE_RESET;
		end else if (!locked_r) begin
			if (PIN_CFG_WR && PIN_CFG_SEL < 4'hA) begin
				pin_cfg_r[PIN_CFG_SEL*spsc_pkg::CFGW +: spsc_pkg::CFGW] <= PIN_CFG_DATA;
			end
			if (SUSP_WR) begin
				susp_mode_r <= SUSP_MODE_DATA & spsc_pkg::SUSP_MODE_MASK;
				susp_state_r <= SUSP_STATE_DATA & spsc_pkg::SUSP_STATE_MASK;
			end
		end
	end

	// Clock output divider; the pin logic forces it low in suspend when override is on
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			div_r <= '0;
			clk_lvl_r <= 1'b0;
		end else if (div_r == DW'(CLKOUT_DIV - 1)) begin
			div_r <= '0;
			clk_lvl_r <= !clk_lvl_r;
		end else begin
			div_r <= div_r + DW'(1);
		end
	end

	// Suspend tracking; outputs are captured on entry so they can be held
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			pwr_r <= spsc_pkg::SPSC_RUN;
			held_out_r <= '0;
			held_oe_n_r <= '1;
		end else begin
			case (pwr_r)
				spsc_pkg::SPSC_RUN: begin
					if (USB_SUSPEND) begin
						pwr_r <= spsc_pkg::SPSC_SUSP;
						held_out_r <= gpio_out_r;
						held_oe_n_r <= gpio_oe_n_r;
					end
				end
				spsc_pkg::SPSC_SUSP: begin
					if (!USB_SUSPEND) begin
						pwr_r <= spsc_pkg::SPSC_RUN;
					end
				end
				default: begin
					pwr_r <= spsc_pkg::SPSC_RUN;
				end
			endcase
		end
	end

	spsc_pin_ctl u_pin_ctl (
		.cfg(pin_cfg_r),
		.flow_en(FLOW_EN),
		.rs485_io1(RS485_IO1),
		.susp_mode(susp_mode_r),
		.susp_state(susp_state_r),
		.gpio_val(GPIO_WR_VAL),
		.func_val(UART_FUNC),
		.clk_lvl(clk_lvl_r),
		.susp(pwr_r == spsc_pkg::SPSC_SUSP),
		.held_out(held_out_r),
		.held_oe_n(held_oe_n_r),
		.norm_out(norm_out),
		.norm_oe_n(norm_oe_n),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n)
	);

	// Pin drivers, released during reset
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			gpio_out_r <= '0;
			gpio_oe_n_r <= '1;
		end else begin
			gpio_out_r <= pin_out;
			gpio_oe_n_r <= pin_oe_n;
		end
	end

	// Set report collection; an overlong report saturates the count and is refused
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			set_cnt_r <= 3'h0;
			set_b0_r <= 8'h00;
			set_b1_r <= 8'h00;
			set_b2_r <= 8'h00;
			set_end_r <= 1'b0;
		end else begin
			set_end_r <= SET_VALID && SET_LAST;
			if (SET_VALID) begin
				if (SET_FIRST) begin
					set_b0_r <= SET_BYTE;
					set_cnt_r <= 3'h1;
				end else begin
					if (set_cnt_r == 3'h1) begin
						set_b1_r <= SET_BYTE;
					end
					if (set_cnt_r == 3'h2) begin
						set_b2_r <= SET_BYTE;
					end
					if (set_cnt_r != spsc_pkg::RPT_LEN_MAX) begin
						set_cnt_r <= set_cnt_r + 3'h1;
					end
				end
			end
		end
	end

	assign ok_lang = set_cnt_r == spsc_pkg::RPT_LEN_LANG && set_b0_r == spsc_pkg::RPT_ID_LANG && !locked_r;
	assign ok_lock = set_cnt_r == spsc_pkg::RPT_LEN_LOCK && set_b0_r == spsc_pkg::RPT_ID_LOCK && !locked_r;

	always_ff @(posedge CLK) begin
		if (rst_any) begin
			lang_r <= spsc_pkg::LANG_RESET;
			set_done_r <= 1'b0;
			set_err_r <= 1'b0;
		end else begin
			set_done_r <= set_end_r && (ok_lang || ok_lock);
			set_err_r <= set_end_r && !(ok_lang || ok_lock);
			if (set_end_r && ok_lang) begin
				lang_r <= {set_b2_r, set_b1_r};
			end
		end
	end

	// A hardware reset keeps the request so that it takes effect; power-on relies on LOCK_STORED
	always_ff @(posedge CLK) begin
		if (POR_RST) begin
			lock_req_r <= 1'b0;
		end else if (!RST && set_end_r && ok_lock && set_b1_r[spsc_pkg::LOCK_REQ_BIT]) begin
			lock_req_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_any) begin
			locked_r <= lock_req_r || LOCK_STORED;
		end
	end

	// Get report answers
	always_ff @(posedge CLK) begin
		if (rst_any) begin
			get_ack_r <= 1'b0;
			get_err_r <= 1'b0;
			get_len_r <= 2'h0;
			get_b0_r <= 8'h00;
			get_b1_r <= 8'h00;
			get_b2_r <= 8'h00;
		end else begin
			get_ack_r <= GET_REQ;
			get_err_r <= 1'b0;
			if (GET_REQ) begin
				get_b0_r <= GET_ID;
				if (GET_ID == spsc_pkg::RPT_ID_LANG) begin
					get_len_r <= spsc_pkg::RPT_LEN_LANG[1:0];
					get_b1_r <= lang_r[7:0];
					get_b2_r <= lang_r[15:8];
				end else if (GET_ID == spsc_pkg::RPT_ID_LOCK) begin
					get_len_r <= spsc_pkg::RPT_LEN_LOCK[1:0];
					get_b1_r <= {7'h00, lock_req_r};
					get_b2_r <= 8'h00;
				end else begin
					get_err_r <= 1'b1;
					get_len_r <= 2'h0;
					get_b1_r <= 8'h00;
					get_b2_r <= 8'h00;
				end
			end
		end
	end

	assign GPIO_OUT = gpio_out_r;
	assign GPIO_OE_N = gpio_oe_n_r;
	assign RX_DATA = rx_data_r;
	assign GPIO_IN_Q = gpio_in_q_r;
	assign CTS_OK = cts_ok_r;
	assign PIN_CFG_Q = pin_cfg_r;
	assign SUSP_MODE_Q = susp_mode_r;
	assign SUSP_STATE_Q = susp_state_r;
	assign SET_DONE = set_done_r;
	assign SET_ERR = set_err_r;
	assign GET_ACK = get_ack_r;
	assign GET_ERR = get_err_r;
	assign GET_LEN = get_len_r;
	assign GET_B0 = get_b0_r;
	assign GET_B1 = get_b1_r;
	assign GET_B2 = get_b2_r;
	assign LOCK_PENDING = lock_req_r;
	assign LOCKED = locked_r;

	// Checks
	logic in_susp, use_ovr;
	assign in_susp = pwr_r == spsc_pkg::SPSC_SUSP;
	assign use_ovr = susp_mode_r[spsc_pkg::SUSP_USE_BIT];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (rst_any);

	sequence s_held;
		(in_susp && !use_ovr) ##1 (in_susp && !use_ovr);
	endsequence
	sequence s_ovr;
		in_susp && use_ovr;
	endsequence

	AST_HOLD: assert property (s_held |=> $stable(GPIO_OUT) && $stable(GPIO_OE_N))
		else $error("pins moved during suspend without override");
	AST_SUSP_LEVEL: assert property (s_ovr and (pin_cfg_r[29:27] == spsc_pkg::CFG_PP && susp_mode_r[13])
		|=> GPIO_OUT[9] == $past(susp_state_r[13]) && !GPIO_OE_N[9])
		else $error("pin 9 ignores its suspend level");
	AST_CLK_LOW: assert property (s_ovr and (pin_cfg_r[2:0] == spsc_pkg::CFG_ALT)
		|=> !GPIO_OUT[0] && !GPIO_OE_N[0])
		else $error("clock output not stopped low in suspend");
	AST_DE3_OFF: assert property (s_ovr and (pin_cfg_r[11:9] == spsc_pkg::CFG_ALT)
		|=> !GPIO_OUT[3] && !GPIO_OE_N[3])
		else $error("driver enable on pin 3 asserted in suspend");
	// A reset anywhere in the three-stage path reloads it with the idle level
	AST_RX_PATH: assert property (!$past(rst_any) && !$past(rst_any, 2) && !$past(rst_any, 3)
		|-> RX_DATA == $past(RX_PIN, 3))
		else $error("receive data path broken");
	AST_DEFAULTS: assert property ($past(rst_any) |-> pin_cfg_r[11:9] == spsc_pkg::PIN_CFG_RESET[11:9]
		&& lang_r == spsc_pkg::LANG_RESET)
		else $error("wrong reset defaults");
	AST_NO_FLOW: assert property (!FLOW_EN && !RS485_IO1 && pwr_r == spsc_pkg::SPSC_RUN
		&& pin_cfg_r[5:3] == spsc_pkg::CFG_ALT |=> GPIO_OE_N[1] && CTS_OK)
		else $error("flow control active while disabled");
	AST_LANG_WR: assert property (set_end_r && ok_lang |=> lang_r == {$past(set_b2_r), $past(set_b1_r)}
		&& set_done_r && !set_err_r)
		else $error("language code write lost");
	AST_LOCK_REQ: assert property (set_end_r && ok_lock && set_b1_r[0] |=> LOCK_PENDING && !$past(LOCKED)
		##[1:2] LOCK_PENDING)
		else $error("lock request not recorded");
	AST_LOCK_DEFER: assert property (!$past(rst_any) |-> $stable(LOCKED))
		else $error("lock changed without a reset");
	AST_RESUME: assert property (!in_susp ##1 !in_susp |=> GPIO_OUT == $past(norm_out)
		&& GPIO_OE_N == $past(norm_oe_n))
		else $error("pins not back to normal after resume");

endmodule : spsc_top

// >>> spsc_host_model.sv
// Host model: issues the HID set and get reports that reach the block.
// Assumes each task is entered 2 ns after a rising clk edge and leaves likewise.
`timescale 1ns/10ps
module spsc_host_model (
	// Clock
	input wire logic clk,
	// Set report byte stream
	output logic set_valid,
	output logic set_first,
	output logic set_last,
	output logic [7:0] set_byte,
	input wire logic set_done,
	input wire logic set_err,
	// Get report
	output logic get_req,
	output logic [7:0] get_id
);
	initial begin
		set_valid = 1'b0;
		set_first = 1'b0;
		set_last = 1'b0;
		set_byte = 8'h5A;
		get_req = 1'b0;
		get_id = 8'hA5;
	end

	// Byte 0 is the report id, then low byte, then high byte
	task automatic send(input int n, input logic [23:0] b, output logic done, output logic err, output logic tmo);
		for (int i = 0; i < n; i++) begin
			set_valid = 1'b1;
			set_first = (i == 0);
			set_last = (i == n - 1);
			set_byte = b[8*i +: 8];
			@(posedge clk);
			#2;
		end
		set_valid = 1'b0;
		set_first = 1'b0;
		set_last = 1'b0;
		// A released byte bus must not keep showing the last value
		set_byte = ~set_byte;
		tmo = 1'b1;
		done = 1'b0;
		err = 1'b0;
		for (int k = 0; k < 8 && tmo; k++) begin
			@(posedge clk);
			#2;
			if (set_done === 1'b1 || set_err === 1'b1) begin
				done = set_done;
				err = set_err;
				tmo = 1'b0;
			end
		end
	endtask : send

	task automatic fetch(input logic [7:0] id);
		get_req = 1'b1;
		get_id = id;
		@(posedge clk);
		#2;
		get_req = 1'b0;
		get_id = ~id;
	endtask : fetch

endmodule : spsc_host_model

// >>> spsc_tb_top.sv
// Self-checking bench for the suspend pin state control block.
// Assumes one 40 MHz core clock; inputs change 2 ns after each rising edge.
`timescale 1ns/10ps
module spsc_tb_top;
	typedef struct packed {
		logic [2:0] n;
		logic [23:0] b;
		logic err;
	} spsc_row_t;
	// Report length, bytes {high, low, id}, refusal expected
	localparam spsc_row_t ROWS [7] = '{
		'{3'h3, 24'h123467, 1'b0}, '{3'h2, 24'h00AA67, 1'b1}, '{3'h3, 24'h000068, 1'b1},
		'{3'h1, 24'h000067, 1'b1}, '{3'h3, 24'h000055, 1'b1}, '{3'h2, 24'h000068, 1'b0},
		'{3'h3, 24'hABCD67, 1'b0}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por_rst = 1'b1;
	logic lock_stored = 1'b0;
	logic rs485_io1 = 1'b0;
	logic [9:0] gpio_in = 10'h3FF;
	logic [9:0] gpio_wr_val = 10'h000;
	logic [9:0] uart_func = 10'h000;
	logic rx_pin = 1'b1;
	logic flow_en = 1'b0;
	logic usb_suspend = 1'b0;
	logic pin_cfg_wr = 1'b0;
	logic [3:0] pin_cfg_sel = 4'h0;
	logic [2:0] pin_cfg_data = 3'h0;
	logic susp_wr = 1'b0;
	logic [15:0] susp_mode_data = 16'h0000;
	logic [15:0] susp_state_data = 16'h0000;
	logic [9:0] gpio_out, gpio_oe_n, gpio_in_q;
	logic rx_data, cts_ok, set_valid, set_first, set_last, set_done, set_err;
	logic get_req, get_ack, get_err, lock_pending, locked;
	logic [7:0] set_byte, get_id, get_b0, get_b1, get_b2;
	logic [1:0] get_len;
	logic [29:0] pin_cfg_q;
	logic [15:0] susp_mode_q, susp_state_q;
	int fail_count = 0;
	int check_count = 0;

	always #12.5 clk = ~clk;

	spsc_top #(.CLKOUT_DIV(1)) i_dut (
		.CLK(clk), .RST(rst), .POR_RST(por_rst), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
		.GPIO_OE_N(gpio_oe_n), .RX_PIN(rx_pin), .RX_DATA(rx_data), .GPIO_IN_Q(gpio_in_q),
		.GPIO_WR_VAL(gpio_wr_val), .UART_FUNC(uart_func), .FLOW_EN(flow_en), .RS485_IO1(rs485_io1),
		.CTS_OK(cts_ok), .USB_SUSPEND(usb_suspend), .PIN_CFG_WR(pin_cfg_wr), .PIN_CFG_SEL(pin_cfg_sel),
		.PIN_CFG_DATA(pin_cfg_data), .PIN_CFG_Q(pin_cfg_q), .SUSP_WR(susp_wr),
		.SUSP_MODE_DATA(susp_mode_data), .SUSP_STATE_DATA(susp_state_data), .SUSP_MODE_Q(susp_mode_q),
		.SUSP_STATE_Q(susp_state_q), .SET_VALID(set_valid), .SET_FIRST(set_first), .SET_LAST(set_last),
		.SET_BYTE(set_byte), .SET_DONE(set_done), .SET_ERR(set_err), .GET_REQ(get_req), .GET_ID(get_id),
		.GET_ACK(get_ack), .GET_ERR(get_err), .GET_LEN(get_len), .GET_B0(get_b0), .GET_B1(get_b1),
		.GET_B2(get_b2), .LOCK_STORED(lock_stored), .LOCK_PENDING(lock_pending), .LOCKED(locked));

	spsc_host_model i_host (
		.clk(clk), .set_valid(set_valid), .set_first(set_first), .set_last(set_last), .set_byte(set_byte),
		.set_done(set_done), .set_err(set_err), .get_req(get_req), .get_id(get_id));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : settle

	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	task automatic run_set(input logic [2:0] n, input logic [23:0] b, input logic err);
		logic done, got_err, tmo;
		i_host.send(n, b, done, got_err, tmo);
		if (tmo !== 1'b0) begin
			fail_count++;
			conclude();
		end else begin
			chk({done, got_err}, {~err, err});
		end
	endtask : run_set

	task automatic get_chk(input logic [7:0] id, input logic [1:0] len, input logic [23:0] exp);
		i_host.fetch(id);
		chk(get_ack, 1'b1);
		chk({get_err, get_len}, {len == 2'h0, len});
		if (len != 2'h0) begin
			chk({get_b0, get_b1}, exp[23:8]);
		end
		if (len == 2'h3) begin
			chk(get_b2, exp[7:0]);
		end
		// Let an edge pass so a following request is not raised in the same step
		settle(1);
	endtask : get_chk

	task automatic wr_susp(input logic [15:0] m, input logic [15:0] s);
		susp_wr = 1'b1;
		susp_mode_data = m;
		susp_state_data = s;
		settle(1);
		susp_wr = 1'b0;
		settle(1);
	endtask : wr_susp

	initial begin
		#200000;
		fail_count++;
		conclude();
	end

	initial begin
		settle(4);
		rst = 1'b0;
		por_rst = 1'b0;
		chk(pin_cfg_q[11:3], 9'h0DB);
		get_chk(8'h67, 2'h3, 24'h670904);
		foreach (ROWS[i]) begin
			run_set(ROWS[i].n, ROWS[i].b, ROWS[i].err);
		end
		get_chk(8'h67, 2'h3, 24'h67CDAB);
		get_chk(8'h68, 2'h2, 24'h680000);
		get_chk(8'h55, 2'h0, 24'h000000);
		$display("test reports finished");
		rx_pin = 1'b0;
		settle(3);
		chk({rx_data, cts_ok, gpio_oe_n[1]}, 3'b011);
		flow_en = 1'b1;
		settle(4);
		chk(cts_ok, 1'b0);
		gpio_in[2] = 1'b0;
		settle(4);
		chk({cts_ok, gpio_in_q}, 11'h7FB);
		$display("test uart pins finished");
		gpio_wr_val = 10'h100;
		uart_func[3] = 1'b1;
		// Pin 0 becomes the clock output
		pin_cfg_wr = 1'b1;
		pin_cfg_data = 3'h3;
		settle(1);
		pin_cfg_wr = 1'b0;
		settle(2);
		chk({gpio_out[8], gpio_out[3], gpio_oe_n[3]}, 3'b110);
		usb_suspend = 1'b1;
		settle(2);
		gpio_wr_val = 10'h000;
		settle(3);
		chk({gpio_out[8], gpio_oe_n[8], gpio_out[3]}, 3'b101);
		usb_suspend = 1'b0;
		settle(3);
		chk(gpio_out[8], 1'b0);
		wr_susp(16'hFFFF, 16'hFFFF);
		chk({susp_mode_q, susp_state_q}, 32'hBCCF3CCF);
		wr_susp(16'hA00F, 16'hFFFF);
		// Pin 1 becomes a driver enable as well
		rs485_io1 = 1'b1;
		usb_suspend = 1'b1;
		settle(3);
		chk({gpio_out[9], gpio_oe_n[9], gpio_oe_n[8], gpio_out[3], gpio_out[0], gpio_oe_n[0]}, 6'h28);
		chk({gpio_out[1], gpio_oe_n[1]}, 2'b00);
		usb_suspend = 1'b0;
		rs485_io1 = 1'b0;
		settle(3);
		chk({gpio_out[9], gpio_out[3]}, 2'b01);
		$display("test suspend finished");
		run_set(3'h2, 24'h000168, 1'b0);
		chk({lock_pending, locked}, 2'b10);
		get_chk(8'h68, 2'h2, 24'h680100);
		rst = 1'b1;
		settle(1);
		rst = 1'b0;
		chk({lock_pending, locked}, 2'b11);
		run_set(3'h3, 24'h111167, 1'b1);
		// The first power-on edge still sees the old request; the second drops the lock
		por_rst = 1'b1;
		settle(2);
		por_rst = 1'b0;
		chk({lock_pending, locked}, 2'b00);
		settle(1);
		lock_stored = 1'b1;
		por_rst = 1'b1;
		settle(2);
		por_rst = 1'b0;
		chk({lock_pending, locked}, 2'b01);
		$display("test lock finished");
		conclude();
	end

endmodule : spsc_tb_top
